// ### tscl_top.sv
// What this block does
// (R1) shutdown bit set stops new conversions
// (R2) one-shot in shutdown runs one conversion
// (R3) alarm-clear write drops alarm, reads zero
// (R4) toggle bit flips on read after conversion
// (R5) alarm status mirrors pin; clears below lower
// (R6) cleared alarm reasserts at next hot conversion
// (R7) high flag sticky until read and cool
// (R8) low flag sticky until read and warm
// (R9) ready bit cleared by read, set on done
// (R10) host waits for ready after one-shot
// (R11) alarm disable forces pin and status inactive
// (R12) sense bit selects alarm active level
// (R13) two-bit field selects 13 to 16 bits
// (R14) host writes zero to bits three, zero
// (R15) reserved bits store and read back
// (R16) upper limit eleven bits, low five zero
// (R17) lower limit same layout, no alarm
// (R18) read pointer is write pointer plus top
// (R19) command byte layout; illegal reads 0000h
// (R20) compare and update flags at result store
module tscl_top
	import tscl_pkg::*;
#(
	parameter int unsigned CONV_CYCLES = CONV_BASE_CYC,
	parameter logic [15:0] IDENT_VALUE = IDENT_DEFAULT
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// serial link pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sio_in,
	output logic             sio_out,
	output logic             sio_oe,
	// converter side
	input  wire logic [15:0] adc_value,
	output logic             conv_active,
	// alarm pin
	output logic             overheat_alarm
);

	// ----------------------------------------------------------------
	// pin synchronisation and edge detection
	// ----------------------------------------------------------------
	logic cs_s;
	logic sclk_s;
	logic sio_s;
	logic cs_n_d_r;
	logic sclk_d_r;

	tscl_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({!cs_n, sclk, sio_in}),
		.q       ({cs_s, sclk_s, sio_s})
	);

	// select travels inverted so the flops reset to the deselected level, no false frame after reset
	wire cs_n_s = !cs_s;

	// delayed copies for edge finding
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_d_r <= 1'b1;
			sclk_d_r <= 1'b0;
		end else begin
			cs_n_d_r <= cs_n_s;
			sclk_d_r <= sclk_s;
		end
	end

	wire frame_start = !cs_n_s && cs_n_d_r;
	wire frame_end   = cs_n_s && !cs_n_d_r;
	wire sclk_rise   = !cs_n_s && sclk_s && !sclk_d_r;
	wire sclk_fall   = !cs_n_s && !sclk_s && sclk_d_r;

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	tscl_cfg_type   cfg_r;
	tscl_phase_type phase_r, phase_nxt;
	logic [4:0]     cnt_r, cnt_nxt;
	logic [15:0]    sh_r, sh_nxt;
	logic [7:0]     cmd_r, cmd_nxt;
	logic           sio_out_nxt;
	logic           sio_oe_nxt;
	logic           rd_fire;
	logic           wr_fire;
	logic [15:0]    upper_r;
	logic [15:0]    lower_r;
	logic [15:0]    temp_r;
	logic           temp_tog_r;
	logic           temp_pend_r;
	logic           ctl_tog_r;
	logic           ctl_pend_r;
	logic           ready_r;
	logic           high_flag_r;
	logic           low_flag_r;
	logic           above_r;
	logic           below_r;
	logic           alarm_r;
	logic           one_shot_pend_r;
	logic           conv_done;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire [7:0]  cmd_full    = {cmd_r[6:0], sio_s};
	wire [2:0]  rd_sel      = cmd_full[2:0];
	wire        rd_pad_ok   = cmd_full[6:3] == CMD_PAD_ZERO;
	wire        rd_is_read  = cmd_full[CMD_RW_BIT];                 // see (R18)
	wire [2:0]  wr_sel      = cmd_r[2:0];
	wire        wr_pad_ok   = cmd_r[6:3] == CMD_PAD_ZERO;           // see (R19)
	wire [15:0] wr_data     = {sh_r[14:0], sio_s};
	wire        wr_ctrl     = wr_fire && wr_pad_ok && wr_sel == REG_CTRL;
	wire        wr_upper    = wr_fire && wr_pad_ok && wr_sel == REG_UPPER;
	wire        wr_lower    = wr_fire && wr_pad_ok && wr_sel == REG_LOWER;
	wire        ctrl_read   = rd_fire && rd_pad_ok && rd_sel == REG_CTRL;

	// ----------------------------------------------------------------
	// resolution and temperature result
	// ----------------------------------------------------------------
	wire [1:0]  precision   = {cfg_r.precision_select_hi, cfg_r.precision_select_lo};
	wire        full_prec   = precision == PREC_16BIT;
	wire [15:0] prec_mask   = PREC_FULL_MASK << (PREC_16BIT - precision);  // see (R13)
	wire [15:0] new_temp    = adc_value & prec_mask;
	wire        new_above   = $signed(new_temp) > $signed(upper_r);        // see (R16)
	wire        new_below   = $signed(new_temp) < $signed(lower_r);        // see (R17)
	wire        temp_tog_nx = temp_tog_r ^ temp_pend_r;
	wire [15:0] temp_out    = {temp_r[15:1], full_prec ? temp_r[0] : temp_tog_nx};

	// ----------------------------------------------------------------
	// read data selection
	// ----------------------------------------------------------------
	wire        ctl_tog_nx  = ctl_tog_r ^ ctl_pend_r;                      // see (R4)
	wire [15:0] ctrl_value  = {cfg_r.shutdown_request, 1'b0, 1'b0,         // see (R2) (R3)
	                           ctl_tog_nx, overheat_alarm, high_flag_r,    // see (R5)
	                           low_flag_r, ready_r, cfg_r.alarm_disable,
	                           cfg_r.alarm_sense_select, precision, 1'b0,
	                           cfg_r.reserved, 1'b0};                      // see (R15)
	wire [15:0] rd_value    = !rd_pad_ok               ? READ_ILLEGAL :    // see (R19)
	                          (rd_sel == REG_CTRL)     ? ctrl_value :
	                          (rd_sel == REG_UPPER)    ? upper_r :
	                          (rd_sel == REG_LOWER)    ? lower_r :
	                          (rd_sel == REG_IDENT)    ? IDENT_VALUE : READ_ILLEGAL;

	// ----------------------------------------------------------------
	// conversion timer
	// ----------------------------------------------------------------
	wire conv_start = !conv_active && (!cfg_r.shutdown_request || one_shot_pend_r);  // see (R1)

	tscl_conv_timer #(
		.CNT_W       (CONV_CNT_W),
		.BASE_CYCLES (CONV_CYCLES)
	) u_timer (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.start     (conv_start),
		.precision (precision),
		.busy      (conv_active),
		.done      (conv_done)
	);

	// ----------------------------------------------------------------
	// serial frame sequencer
	// ----------------------------------------------------------------
	always_comb begin
		phase_nxt   = phase_r;
		cnt_nxt     = cnt_r;
		sh_nxt      = sh_r;
		cmd_nxt     = cmd_r;
		sio_out_nxt = sio_out;
		sio_oe_nxt  = sio_oe;
		rd_fire     = 1'b0;
		wr_fire     = 1'b0;
		if (frame_end) begin
			phase_nxt  = PH_IDLE;
			sio_oe_nxt = 1'b0;
		end else if (frame_start) begin
			phase_nxt   = PH_TEMP;
			cnt_nxt     = '0;
			sh_nxt      = {temp_out[14:0], 1'b0};
			sio_out_nxt = temp_out[DATA_W-1];
			sio_oe_nxt  = 1'b1;
		end else if (sclk_rise) begin
			cnt_nxt = cnt_r + 5'h01;
			case (phase_r)
				PH_TEMP: begin
					if (cnt_r == DATA_LAST) begin
						phase_nxt  = PH_CMD;
						cnt_nxt    = '0;
						sio_oe_nxt = 1'b0;
					end
				end
				PH_CMD: begin
					cmd_nxt = cmd_full;
					if (cnt_r == CMD_LAST) begin
						cnt_nxt = '0;
						if (rd_is_read) begin
							phase_nxt  = PH_RDATA;
							sh_nxt     = rd_value;
							sio_oe_nxt = 1'b1;
							rd_fire    = 1'b1;
						end else begin
							phase_nxt = PH_WDATA;
						end
					end
				end
				PH_RDATA: begin
					if (cnt_r == DATA_LAST) begin
						phase_nxt  = PH_DONE;
						sio_oe_nxt = 1'b0;
					end
				end
				PH_WDATA: begin
					sh_nxt = wr_data;
					if (cnt_r == DATA_LAST) begin
						phase_nxt = PH_DONE;
						wr_fire   = 1'b1;
					end
				end
				default: begin
					cnt_nxt = cnt_r;
				end
			endcase
		end else if (sclk_fall && (phase_r == PH_TEMP || phase_r == PH_RDATA)) begin
			sio_out_nxt = sh_r[DATA_W-1];
			sh_nxt      = {sh_r[14:0], 1'b0};
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= PH_IDLE;
			cnt_r   <= '0;
			sh_r    <= '0;
			cmd_r   <= '0;
			sio_out <= 1'b0;
			sio_oe  <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			cmd_r   <= cmd_nxt;
			sio_out <= sio_out_nxt;
			sio_oe  <= sio_oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// configuration and limit registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r   <= CFG_RST;
			upper_r <= UPPER_RST;
			lower_r <= LOWER_RST;
		end else begin
			if (wr_ctrl) begin
				cfg_r.shutdown_request    <= wr_data[CTL_SHUTDOWN];     // see (R1)
				cfg_r.alarm_disable       <= wr_data[CTL_ALARM_DIS];    // see (R11)
				cfg_r.alarm_sense_select  <= wr_data[CTL_SENSE];        // see (R12)
				cfg_r.precision_select_hi <= wr_data[CTL_PREC_HI];      // see (R13)
				cfg_r.precision_select_lo <= wr_data[CTL_PREC_LO];
				cfg_r.reserved            <= wr_data[CTL_RSV_HI:CTL_RSV_LO];  // see (R15)
			end
			if (wr_upper)
				upper_r <= wr_data & LIMIT_MASK;                       // see (R16)
			if (wr_lower)
				lower_r <= wr_data & LIMIT_MASK;                       // see (R17)
		end
	end

	// one-shot request only while already in shutdown
	wire one_shot_wr = wr_ctrl && wr_data[CTL_ONE_SHOT] && wr_data[CTL_SHUTDOWN]
	                   && cfg_r.shutdown_request;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			one_shot_pend_r <= 1'b0;
		else if (one_shot_wr)
			one_shot_pend_r <= 1'b1;                                   // see (R2)
		else if (conv_start)
			one_shot_pend_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// temperature result and its toggle bit
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			temp_r      <= TEMP_RST;
			temp_tog_r  <= 1'b0;
			temp_pend_r <= 1'b0;
		end else begin
			if (conv_done)
				temp_r <= new_temp;                                    // see (R20)
			if (frame_start)
				temp_tog_r <= temp_tog_nx;
			temp_pend_r <= conv_done || (temp_pend_r && !frame_start);
		end
	end

	// ----------------------------------------------------------------
	// status flags; a conversion event wins over a read clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_tog_r   <= 1'b0;
			ctl_pend_r  <= 1'b0;
			ready_r     <= 1'b0;
			above_r     <= 1'b0;
			below_r     <= 1'b0;
			high_flag_r <= 1'b0;
			low_flag_r  <= 1'b0;
		end else begin
			if (ctrl_read)
				ctl_tog_r <= ctl_tog_nx;                               // see (R4)
			ctl_pend_r  <= conv_done || (ctl_pend_r && !ctrl_read);
			ready_r     <= conv_done || (ready_r && !ctrl_read && !one_shot_wr);  // see (R9)
			if (conv_done) begin
				above_r <= new_above;                                  // see (R20)
				below_r <= new_below;
			end
			high_flag_r <= (conv_done && new_above)
			               || (high_flag_r && !(ctrl_read && !above_r));  // see (R7)
			low_flag_r  <= (conv_done && new_below)
			               || (low_flag_r && !(ctrl_read && !below_r));   // see (R8)
		end
	end

	// ----------------------------------------------------------------
	// alarm state and pin
	// ----------------------------------------------------------------
	wire alarm_clr_wr = wr_ctrl && wr_data[CTL_ALARM_CLR];
	wire alarm_nxt    = (conv_done && new_above) ? 1'b1 :                // see (R6)
	                    (alarm_clr_wr || (conv_done && new_below)) ? 1'b0 :  // see (R3) (R5)
	                    alarm_r;
	wire alarm_active = alarm_nxt && !cfg_r.alarm_disable;               // see (R11)

	// pin registers from the next state on the same edge as alarm_r; status reads the pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alarm_r        <= 1'b0;
			overheat_alarm <= 1'b1;
		end else begin
			alarm_r        <= alarm_nxt;
			overheat_alarm <= cfg_r.alarm_sense_select ? alarm_active : !alarm_active;  // see (R12)
		end
	end

endmodule

// ### tscl_pkg.sv
package tscl_pkg;

	// ----------------------------------------------------------------
	// clock and conversion timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CONV_TIME_US    = 50_000;   // base conversion time, lowest resolution
	localparam int unsigned CONV_BASE_CYC   = CONV_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CONV_CNT_W      = 24;

	// ----------------------------------------------------------------
	// serial frame layout
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned CMD_W           = 8;
	localparam logic [4:0]  DATA_LAST       = 5'h0f;
	localparam logic [4:0]  CMD_LAST        = 5'h07;
	localparam int unsigned CMD_RW_BIT      = 7;
	localparam logic [3:0]  CMD_PAD_ZERO    = 4'h0;

	// ----------------------------------------------------------------
	// register select codes
	// ----------------------------------------------------------------
	localparam logic [2:0]  REG_CTRL        = 3'h1;
	localparam logic [2:0]  REG_UPPER       = 3'h2;
	localparam logic [2:0]  REG_LOWER       = 3'h3;
	localparam logic [2:0]  REG_IDENT       = 3'h7;

	// ----------------------------------------------------------------
	// control_and_status field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTL_SHUTDOWN    = 15;
	localparam int unsigned CTL_ONE_SHOT    = 14;
	localparam int unsigned CTL_ALARM_CLR   = 13;
	localparam int unsigned CTL_TOGGLE      = 12;
	localparam int unsigned CTL_ALARM_STAT  = 11;
	localparam int unsigned CTL_HIGH_FLAG   = 10;
	localparam int unsigned CTL_LOW_FLAG    = 9;
	localparam int unsigned CTL_READY       = 8;
	localparam int unsigned CTL_ALARM_DIS   = 7;
	localparam int unsigned CTL_SENSE       = 6;
	localparam int unsigned CTL_PREC_HI     = 5;
	localparam int unsigned CTL_PREC_LO     = 4;
	localparam int unsigned CTL_RSV_HI      = 2;
	localparam int unsigned CTL_RSV_LO      = 1;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RST        = 16'h0000;
	localparam logic [15:0] UPPER_RST       = 16'h4880;
	localparam logic [15:0] LOWER_RST       = 16'h4600;
	localparam logic [15:0] TEMP_RST        = 16'h0000;
	localparam logic [15:0] READ_ILLEGAL    = 16'h0000;
	localparam logic [15:0] LIMIT_MASK      = 16'hffe0;
	localparam logic [15:0] PREC_FULL_MASK  = 16'hffff;
	localparam logic [1:0]  PREC_16BIT      = 2'h3;
	localparam logic [15:0] IDENT_DEFAULT   = 16'h5a01; // arbitrary value

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum {PH_IDLE, PH_TEMP, PH_CMD, PH_RDATA, PH_WDATA, PH_DONE} tscl_phase_type;

	typedef struct packed {
		logic       shutdown_request;
		logic       alarm_disable;
		logic       alarm_sense_select;
		logic       precision_select_hi;
		logic       precision_select_lo;
		logic [1:0] reserved;
	} tscl_cfg_type;

	localparam tscl_cfg_type CFG_RST = '{default: 1'b0};

endpackage

// ### tscl_sync.sv
module tscl_sync
	import tscl_pkg::*;
#(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// two-flop synchroniser; meta_r feeds only q
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ### tscl_conv_timer.sv
module tscl_conv_timer
	import tscl_pkg::*;
#(
	parameter int unsigned CNT_W       = CONV_CNT_W,
	parameter int unsigned BASE_CYCLES = CONV_BASE_CYC
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [1:0] precision,
	// status
	output logic            busy,
	output logic            done
);

	logic [CNT_W-1:0] cnt_r;
	wire  [CNT_W-1:0] load_val = (CNT_W'(BASE_CYCLES) << precision) - CNT_W'(1);

	// each extra bit of precision doubles the conversion time
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				cnt_r <= load_val;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_r == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - CNT_W'(1);
				end
			end
		end
	end

endmodule

// ### tscl_checker.sv
module tscl_checker
	import tscl_pkg::*;
#(
	parameter int unsigned CONV_CYCLES = CONV_BASE_CYC
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// serial link
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        sio_in,
	input wire logic        sio_out,
	input wire logic        sio_oe,
	// converter and alarm
	input wire logic [15:0] adc_value,
	input wire logic        conv_active,
	input wire logic        overheat_alarm
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// length of the running conversion, cycles since a frame or conversion end
	logic [23:0] run_r;
	logic [3:0]  quiet_r;
	logic        act_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_r   <= '0;
			quiet_r <= '0;
			act_r   <= 1'b0;
		end else begin
			run_r   <= conv_active ? run_r + 24'h1 : '0;
			act_r   <= conv_active;
			quiet_r <= (!cs_n || (act_r && !conv_active)) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
		end
	end

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	chk_conv_length: assert property ($fell(conv_active) |->
		run_r >= CONV_CYCLES - 1 && run_r <= (CONV_CYCLES << 3) + 1) else $error("conversion length out of range");
	chk_conv_start: assert property ($rose(rst_n) |-> ##[0:2] conv_active)
		else $error("no conversion after reset");

	// ----------------------------------------------------------------
	// alarm pin
	// ----------------------------------------------------------------
	chk_alarm_reset: assert property ($rose(rst_n) |-> overheat_alarm)
		else $error("alarm pin active after reset");
	chk_alarm_cause: assert property ($changed(overheat_alarm) |-> quiet_r < 4'h6)
		else $error("alarm pin moved without a cause");

	// ----------------------------------------------------------------
	// serial data wire
	// ----------------------------------------------------------------
	chk_oe_start: assert property ($fell(cs_n) |-> ##[1:6] sio_oe)
		else $error("temperature not driven at frame start");
	chk_oe_idle: assert property (cs_n [*6] |-> !sio_oe)
		else $error("data wire driven outside a frame");
	chk_out_on_fall: assert property ($changed(sio_out) && !cs_n |-> !$past(sclk))
		else $error("data changed while serial clock high");
	chk_oe_release: assert property ($fell(sio_oe) && !cs_n |-> $past(sclk))
		else $error("data wire released off a rising edge");

	// main scenarios
	cover property ($fell(cs_n));
	cover property ($fell(overheat_alarm));
	cover property ($fell(conv_active) && run_r > CONV_CYCLES * 4);
endmodule

bind tscl_top tscl_checker #(.CONV_CYCLES(CONV_CYCLES)) i_tscl_checker (.clk_sys(clk_sys), .rst_n(rst_n),
	.cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .adc_value(adc_value),
	.conv_active(conv_active), .overheat_alarm(overheat_alarm));

// ### tscl_host_model.sv
module tscl_host_model (
	// system clock
	input  wire logic clk_sys,
	// serial link
	output logic      cs_n,
	output logic      sclk,
	output logic      sio_in,
	input  wire logic sio_out,
	input  wire logic sio_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hd = 1'b0;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	// shared wire: device when enabled, else host or a changing pattern
	assign sio_in = sio_oe ? sio_out : hd;

	// one frame: 16 temperature bits, command byte, 16 data bits, msb first
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdat, output logic [15:0] temp,
		output logic [15:0] rdat);
		logic [23:0] sh;
		sh = {cmd, wdat};
		@(negedge clk_sys);
		cs_n = 1'b0;
		for (int i = 0; i < 40; i++) begin
			hd = (i >= 16 && (i < 24 || !cmd[7])) ? sh[39-i] : ~hd;
			repeat (4) @(negedge clk_sys);
			if (i < 16)
				temp[15-i] = sio_in;
			else if (i >= 24)
				rdat[39-i] = sio_in;
			sclk = 1'b1;
			repeat (4) @(negedge clk_sys);
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk_sys);
		cs_n = 1'b1;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule

// ### testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tscl_pkg::*;
	localparam int unsigned CONV = 200;
	logic        clk_sys   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [15:0] adc_value = 16'h4700;
	logic [15:0] t, r, v;
	logic        tgl       = 1'b1;
	logic [7:0]  bad [5]   = '{8'h80, 8'h84, 8'h86, 8'h8b, 8'hcb};
	int          n_errors  = 0;
	int          compares  = 0;
	wire         cs_n, sclk, sio_in, sio_out, sio_oe, conv_active, overheat_alarm;

	// clock
	always #20 clk_sys = ~clk_sys;

	// design and host
	tscl_top #(.CONV_CYCLES(CONV)) i_tscl_top (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
		.sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .adc_value(adc_value), .conv_active(conv_active),
		.overheat_alarm(overheat_alarm));
	tscl_host_model i_tscl_host_model (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
		.sio_out(sio_out), .sio_oe(sio_oe));

	// ----------------------------------------------------------------
	// compares, bus access, expectations
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: pin %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [2:0] sel, output logic [15:0] d);
		i_tscl_host_model.xfer({1'b1, 4'h0, sel}, 16'h0, t, d);
	endtask
	task automatic wr(input logic [2:0] sel, input logic [15:0] d);
		i_tscl_host_model.xfer({1'b0, 4'h0, sel}, d, t, r);
	endtask
	task automatic conv_end();
		int i;
		i = 0;
		while (conv_active !== 1'b1 && i < 4000) begin
			@(negedge clk_sys);
			i++;
		end
		while (conv_active !== 1'b0 && i < 4000) begin
			@(negedge clk_sys);
			i++;
		end
		chk({15'h0, i < 4000}, 16'h1);
		repeat (4) @(negedge clk_sys);
	endtask
	function automatic logic [15:0] pmask(input logic [1:0] p);
		return (16'hffff << (2'h3 - p)) & {15'h7fff, p == 2'h3};
	endfunction
	task automatic report_and_stop();
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog
	initial begin
		#(90000 * 40);
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hd347));
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(REG_UPPER, v); chk(v, UPPER_RST);
		rd(REG_LOWER, v); chk(v, LOWER_RST);
		rd(REG_CTRL, v); chk(v & 16'heeff, 16'h0800);
		rd(REG_IDENT, v); chk(v, IDENT_DEFAULT);
		// precision, reserved bits, toggle and ready
		for (int p = 0; p < 4; p++) begin
			adc_value = 16'($urandom);
			wr(REG_CTRL, {10'h0, 2'(p), 4'h6});
			conv_end();
			conv_end();
			rd(REG_CTRL, v); chk(v & 16'h00ff, {10'h0, 2'(p), 4'h6});
			tgl = ~tgl;
			chk(v & 16'h1100, {3'h0, tgl, 3'h0, 1'b1, 8'h0});
			chk(t & pmask(2'(p)), adc_value & pmask(2'(p)));
			if (p == 3) begin
				rd(REG_CTRL, v); chk(v & 16'h1100, {3'h0, tgl, 12'h0});
			end
		end
		// limits and illegal commands
		foreach (bad[k]) begin
			v = 16'($urandom);
			wr(REG_LOWER, v);
			i_tscl_host_model.xfer(bad[k] & 8'h7f, ~v, t, r);
			i_tscl_host_model.xfer(bad[k], 16'h0, t, r); chk(r, READ_ILLEGAL);
			rd(REG_LOWER, r); chk(r, v & LIMIT_MASK);
			wr(REG_UPPER, ~v);
			rd(REG_UPPER, r); chk(r, ~v & LIMIT_MASK);
		end
		// alarm set, clear, reassert, polarity, disable
		wr(REG_UPPER, 16'h1000);
		wr(REG_LOWER, 16'h0800);
		adc_value = 16'h2000;
		conv_end(); chk_pin(overheat_alarm, 1'b0);
		rd(REG_CTRL, v); // drops a low flag left by the random limits
		rd(REG_CTRL, v); chk(v & 16'h0e00, 16'h0400);
		wr(REG_CTRL, 16'h2036); chk_pin(overheat_alarm, 1'b1);
		rd(REG_CTRL, v); chk(v & 16'h2800, 16'h0800);
		conv_end(); chk_pin(overheat_alarm, 1'b0);
		wr(REG_CTRL, 16'h0076); chk_pin(overheat_alarm, 1'b1);
		wr(REG_CTRL, 16'h00f6); chk_pin(overheat_alarm, 1'b0);
		rd(REG_CTRL, v); chk(v & 16'h0800, 16'h0000);
		wr(REG_CTRL, 16'h0076);
		adc_value = 16'h0000;
		conv_end(); chk_pin(overheat_alarm, 1'b0);
		rd(REG_CTRL, v); chk(v & 16'h0e00, 16'h0600);
		adc_value = 16'h0c00;
		conv_end();
		rd(REG_CTRL, v);
		rd(REG_CTRL, v); chk(v & 16'h0600, 16'h0000);
		// shutdown held past a full conversion, then one-shot
		wr(REG_CTRL, 16'h8036);
		conv_end();
		repeat (2000) @(negedge clk_sys);
		chk_pin(conv_active, 1'b0);
		adc_value = 16'($urandom);
		wr(REG_CTRL, 16'hc036);
		v = 16'h0;
		for (int k = 0; k < 12 && v[8] !== 1'b1; k++)
			rd(REG_CTRL, v);
		chk(v & 16'h4100, 16'h0100);
		rd(REG_CTRL, v); chk(t, adc_value);
		chk_pin(conv_active, 1'b0);
		wr(REG_CTRL, 16'h0036);
		conv_end();
		report_and_stop();
	end
endmodule
